// ===== verilog/lcgs_gate_select.sv
// Overview of operation
// - Gate two ORs in the true and inverted forms of data inputs 4..1 as its select bits 7..0 say, set includes.
// - Gate three uses the same pairing, odd bits true forms and even bits inverted forms, each active while set.
// - Gate four uses the same pairing, bit 7 true input 4 down to bit 0 inverted input 1, clear removes.
// - Gate select registers are read/write, undefined at power-on and kept through every other reset.
// - The mirror register shows the outputs of cells 4..1 in bits 3..0, read-only, reset to zero.
// - Bits 7..4 of the mirror register always read as zero.
// - Gate one has its own 8-bit select register with the same bit order as the others.
// - Each gate output may be inverted by its own polarity bit, and passes unchanged while the bit is clear.
// - Each data input is picked by its own 5-bit source field and feeds the gates in true and inverted form.
// - The mirrored status is the cell output after the final output inversion.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Register map, one byte per offset
//   0x0 gate one select
//   0x1 gate two select
//   0x2 gate three select
//   0x3 gate four select
//   0x4 polarity: bit 7 cell output invert, bits 3..0 gate four..one invert
//   0x5..0x8 source fields of data inputs one..four, bits 4..0
//   0x9 cell output mirror, bits 3..0, read-only
//   0xa..0xf unmapped: writes dropped, reads answer zero
// Select byte layout, the same for all four gates
//   bit 7 input 4 true, bit 6 input 4 inverted
//   bit 5 input 3 true, bit 4 input 3 inverted
//   bit 3 input 2 true, bit 2 input 2 inverted
//   bit 1 input 1 true, bit 0 input 1 inverted
// Timing seen from the bus
//   A write lands on its strobe edge; gate outputs follow one edge later
//   Read data stand for one cycle after the strobe edge and are zero otherwise
//   A source pin change reaches the gate outputs five edges later
//   A source pulse of one cycle never passes the agreement filter
// Resets and clock enable
//   The power-on reset acts even while the clock enable is low
//   Power-on leaves every select at zero, standing in for an unknown value
//   Other resets need the enable and clear the mirror, the cell invert bit and the read data
//   Selections, gate polarity and source fields survive other resets
//   With the enable low nothing moves, bus strobes included
//   Trade-off: three flops, the filter and the gate output register cost five cycles of latency on every source
module lcgs_gate_select (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  input wire logic ce_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [31:0] src_i,
  input wire logic [3:0] cell_status_i,
  output logic [3:0] gate_o,
  output logic cell_output_invert_o
);

  lcgs_pkg::lcgs_state_s state_r;
  lcgs_pkg::lcgs_state_s state_nxt;
  lcgs_pkg::lcgs_req_s req;

  // Bundle the plain bus port for the decode below
  // One assignment drives the whole struct, field order as declared
  assign req = {reg_addr_i, reg_wdata_i, reg_we_i, reg_re_i};

  // Write strobes, one per register
  // The mirror and the unmapped offsets get none, so writes there are dropped
  logic wr_gate_one;
  logic wr_gate_two;
  logic wr_gate_three;
  logic wr_gate_four;
  logic wr_polarity;
  logic wr_src_one;
  logic wr_src_two;
  logic wr_src_three;
  logic wr_src_four;

  // write decode
  // Qualified by the write enable and the address only; the clock enable gates the registers themselves
  always_comb begin
    wr_gate_one = req.we && (req.addr == lcgs_pkg::OFF_GATE1_SEL);
    wr_gate_two = req.we && (req.addr == lcgs_pkg::OFF_GATE2_SEL);
    wr_gate_three = req.we && (req.addr == lcgs_pkg::OFF_GATE3_SEL);
    wr_gate_four = req.we && (req.addr == lcgs_pkg::OFF_GATE4_SEL);
    wr_polarity = req.we && (req.addr == lcgs_pkg::OFF_POLARITY);
    wr_src_one = req.we && (req.addr == lcgs_pkg::OFF_SRC1);
    wr_src_two = req.we && (req.addr == lcgs_pkg::OFF_SRC2);
    wr_src_three = req.we && (req.addr == lcgs_pkg::OFF_SRC3);
    wr_src_four = req.we && (req.addr == lcgs_pkg::OFF_SRC4);
  end

  // Gate sources and read mux, all from the registered state
  logic [3:0] data_in;
  logic [7:0] cand;
  logic gate_one_hit;
  logic gate_two_hit;
  logic gate_three_hit;
  logic gate_four_hit;
  logic [3:0] gate_raw;
  logic [7:0] read_val;

  // source field mux
  // Each data input picks one cleaned source; the field covers all 32 candidates
  always_comb begin
    for (int i = 0; i < lcgs_pkg::NUM_INPUTS; i++) begin
      data_in[i] = state_r.src_clean[state_r.src_sel[i]];
    end
  end

  // pairing order
  // True form on the odd bit, inverted form on the even bit of each pair
  // All four gates see the same eight candidates; only their select bytes differ
  always_comb begin
    cand[7] = data_in[3]; // Input 4 true
    cand[6] = ~data_in[3]; // Input 4 inverted
    cand[5] = data_in[2]; // Input 3 true
    cand[4] = ~data_in[2]; // Input 3 inverted
    cand[3] = data_in[1]; // Input 2 true
    cand[2] = ~data_in[1]; // Input 2 inverted
    cand[1] = data_in[0]; // Input 1 true
    cand[0] = ~data_in[0]; // Input 1 inverted
  end

  // gate one
  // Masked OR of the candidates under the gate one select byte
  lcgs_gate_or #(
    .CAND_W(lcgs_pkg::DATA_W)
  ) lcgs_gate_or_one_i (
    .cand_i(cand),
    .sel_i(state_r.gate_sel[0]),
    .hit_o(gate_one_hit)
  );

  // gate two
  // Masked OR of the candidates under the gate two select byte
  lcgs_gate_or #(
    .CAND_W(lcgs_pkg::DATA_W)
  ) lcgs_gate_or_two_i (
    .cand_i(cand),
    .sel_i(state_r.gate_sel[1]),
    .hit_o(gate_two_hit)
  );

  // gate three
  // Masked OR of the candidates under the gate three select byte
  lcgs_gate_or #(
    .CAND_W(lcgs_pkg::DATA_W)
  ) lcgs_gate_or_three_i (
    .cand_i(cand),
    .sel_i(state_r.gate_sel[2]),
    .hit_o(gate_three_hit)
  );

  // gate four
  // Masked OR of the candidates under the gate four select byte
  lcgs_gate_or #(
    .CAND_W(lcgs_pkg::DATA_W)
  ) lcgs_gate_or_four_i (
    .cand_i(cand),
    .sel_i(state_r.gate_sel[3]),
    .hit_o(gate_four_hit)
  );

  // gate results
  // Gate one lands in bit 0 so the polarity bits line up one to one
  always_comb begin
    gate_raw = {gate_four_hit, gate_three_hit, gate_two_hit, gate_one_hit};
  end

  // Read mux; unmapped offsets answer zero
  always_comb begin
    read_val = lcgs_pkg::RDATA_RST;
    unique case (req.addr)
      lcgs_pkg::OFF_GATE1_SEL: read_val = state_r.gate_sel[0];
      lcgs_pkg::OFF_GATE2_SEL: read_val = state_r.gate_sel[1];
      lcgs_pkg::OFF_GATE3_SEL: read_val = state_r.gate_sel[2];
      lcgs_pkg::OFF_GATE4_SEL: read_val = state_r.gate_sel[3];
      lcgs_pkg::OFF_POLARITY: begin
        read_val[lcgs_pkg::POL_CELL_BIT] = state_r.cell_pol;
        read_val[lcgs_pkg::POL_GATE_MSB:0] = state_r.gate_pol;
      end
      lcgs_pkg::OFF_SRC1: read_val[lcgs_pkg::SRC_W-1:0] = state_r.src_sel[0];
      lcgs_pkg::OFF_SRC2: read_val[lcgs_pkg::SRC_W-1:0] = state_r.src_sel[1];
      lcgs_pkg::OFF_SRC3: read_val[lcgs_pkg::SRC_W-1:0] = state_r.src_sel[2];
      lcgs_pkg::OFF_SRC4: read_val[lcgs_pkg::SRC_W-1:0] = state_r.src_sel[3];
      lcgs_pkg::OFF_MIRROR: read_val[lcgs_pkg::MIRROR_MSB:0] = state_r.mirror;
      default: read_val = lcgs_pkg::RDATA_RST;
    endcase
  end

  // Next-state logic for the whole block
  always_comb begin
    state_nxt = state_r;

    // Three-stage pin synchroniser; stage one feeds stage two only
    state_nxt.sync1 = src_i;
    state_nxt.sync2 = state_r.sync1;
    state_nxt.sync3 = state_r.sync2;
    // A source changes only once stages two and three agree, which filters single-cycle glitches
    for (int s = 0; s < lcgs_pkg::NUM_SRC; s++) begin
      if (state_r.sync2[s] == state_r.sync3[s]) begin
        state_nxt.src_clean[s] = state_r.sync3[s];
      end
    end

    // per-gate output inversion
    // Registered so the function stage sees a clean level
    state_nxt.gate_out = gate_raw ^ state_r.gate_pol;

    // live mirror of cell outputs
    // Cells present their status already after their final inversion
    state_nxt.mirror = cell_status_i;

    // software writes to the select registers
    // The mirror offset has no strobe, so it takes no write at all
    // gate one..four select
    if (wr_gate_one) begin
      state_nxt.gate_sel[0] = req.wdata;
    end
    if (wr_gate_two) begin
      state_nxt.gate_sel[1] = req.wdata;
    end
    if (wr_gate_three) begin
      state_nxt.gate_sel[2] = req.wdata;
    end
    if (wr_gate_four) begin
      state_nxt.gate_sel[3] = req.wdata;
    end
    // polarity byte
    // Bits 6..4 are not stored and read back as zero
    if (wr_polarity) begin
      state_nxt.cell_pol = req.wdata[lcgs_pkg::POL_CELL_BIT];
      state_nxt.gate_pol = req.wdata[lcgs_pkg::POL_GATE_MSB:0];
    end
    // source fields
    // Bits 7..5 of each field byte are not stored
    if (wr_src_one) begin
      state_nxt.src_sel[0] = req.wdata[lcgs_pkg::SRC_W-1:0];
    end
    if (wr_src_two) begin
      state_nxt.src_sel[1] = req.wdata[lcgs_pkg::SRC_W-1:0];
    end
    if (wr_src_three) begin
      state_nxt.src_sel[2] = req.wdata[lcgs_pkg::SRC_W-1:0];
    end
    if (wr_src_four) begin
      state_nxt.src_sel[3] = req.wdata[lcgs_pkg::SRC_W-1:0];
    end

    // Read data stands only in the cycle after the strobe
    state_nxt.rdata = req.re ? read_val : lcgs_pkg::RDATA_RST;

    // Other resets clear the mirror and cell inversion but keep all selections
    if (soft_rst_i) begin
      state_nxt.mirror = lcgs_pkg::MIRROR_RST;
      state_nxt.cell_pol = lcgs_pkg::CELL_POL_RST;
      state_nxt.rdata = lcgs_pkg::RDATA_RST;
    end
  end

  // power-on reset gives every field a defined value
  // Hardware cannot hold an unknown, so zero stands in for it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r.sync1 <= lcgs_pkg::SRC_SYNC_RST;
      state_r.sync2 <= lcgs_pkg::SRC_SYNC_RST;
      state_r.sync3 <= lcgs_pkg::SRC_SYNC_RST;
      state_r.src_clean <= lcgs_pkg::SRC_SYNC_RST;
      state_r.gate_sel <= {lcgs_pkg::NUM_GATES{lcgs_pkg::GATE_SEL_RST}};
      state_r.gate_pol <= lcgs_pkg::GATE_POL_RST;
      state_r.cell_pol <= lcgs_pkg::CELL_POL_RST;
      state_r.src_sel <= {lcgs_pkg::NUM_INPUTS{lcgs_pkg::SRC_SEL_RST}};
      state_r.mirror <= lcgs_pkg::MIRROR_RST;
      state_r.gate_out <= lcgs_pkg::GATE_POL_RST;
      state_r.rdata <= lcgs_pkg::RDATA_RST;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_o = state_r.rdata;
  assign gate_o = state_r.gate_out;
  assign cell_output_invert_o = state_r.cell_pol;

endmodule : lcgs_gate_select

// One selectable gate of the cell
// Kept as its own module so all four gates are the same netlist
module lcgs_gate_or #(
  parameter int unsigned CAND_W = lcgs_pkg::DATA_W
) (
  input wire logic [CAND_W-1:0] cand_i,
  input wire logic [CAND_W-1:0] sel_i,
  output logic hit_o
);

  // masked OR
  // An empty selection masks every candidate, so the gate rests at zero
  assign hit_o = |(cand_i & sel_i);

endmodule : lcgs_gate_or
`default_nettype wire

// ===== verilog/lcgs_pkg.sv
`default_nettype none
package lcgs_pkg;
  // Register word geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_GATES = 4;
  localparam int unsigned NUM_INPUTS = 4;
  localparam int unsigned SRC_W = 5;
  localparam int unsigned NUM_SRC = 32;
  localparam int unsigned NUM_CELLS = 4;

  // Register offsets
  localparam logic [3:0] OFF_GATE1_SEL = 4'h0;
  localparam logic [3:0] OFF_GATE2_SEL = 4'h1;
  localparam logic [3:0] OFF_GATE3_SEL = 4'h2;
  localparam logic [3:0] OFF_GATE4_SEL = 4'h3;
  localparam logic [3:0] OFF_POLARITY = 4'h4;
  localparam logic [3:0] OFF_SRC1 = 4'h5;
  localparam logic [3:0] OFF_SRC2 = 4'h6;
  localparam logic [3:0] OFF_SRC3 = 4'h7;
  localparam logic [3:0] OFF_SRC4 = 4'h8;
  localparam logic [3:0] OFF_MIRROR = 4'h9;

  // Field positions
  localparam int unsigned POL_CELL_BIT = 7;
  localparam int unsigned POL_GATE_MSB = 3;
  localparam int unsigned MIRROR_MSB = 3;

  // Reset values
  localparam logic [7:0] GATE_SEL_RST = 8'h00;
  localparam logic [3:0] GATE_POL_RST = 4'h0;
  localparam logic CELL_POL_RST = 1'b0;
  localparam logic [4:0] SRC_SEL_RST = 5'h00;
  localparam logic [3:0] MIRROR_RST = 4'h0;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [31:0] SRC_SYNC_RST = 32'h00000000;

  // Software request as seen by the slave
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } lcgs_req_s;

  // Whole state of the gate-select block
  typedef struct packed {
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] sync3;
    logic [31:0] src_clean;
    logic [3:0][7:0] gate_sel;
    logic [3:0] gate_pol;
    logic cell_pol;
    logic [3:0][4:0] src_sel;
    logic [3:0] mirror;
    logic [3:0] gate_out;
    logic [7:0] rdata;
  } lcgs_state_s;
endpackage : lcgs_pkg
`default_nettype wire

// ===== sim/lcgs_gate_select_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lcgs_gate_select_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  input wire logic ce_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [31:0] src_i,
  input wire logic [3:0] cell_status_i,
  input wire logic [3:0] gate_o,
  input wire logic cell_output_invert_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Read port, mirror and control register relations
  property p_rd_idle; ce_i && !reg_re_i |=> reg_rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_mir_hi; ce_i && reg_re_i && reg_addr_i == 4'h9 |=> reg_rdata_o[7:4] == 4'h0; endproperty
  a_mir_hi: assert property (p_mir_hi) else $error("mirror upper bits");
  property p_mir_val; ce_i && reg_re_i && reg_addr_i == 4'h9 && !soft_rst_i && $past(ce_i) && !$past(rst_i)
    && !$past(soft_rst_i) |=> reg_rdata_o[3:0] == $past(cell_status_i, 2); endproperty
  a_mir_val: assert property (p_mir_val) else $error("mirror value");
  property p_sel_rw; ce_i && reg_we_i && reg_addr_i < 4'h4 ##1 !reg_we_i ##1 ce_i && reg_re_i
    && reg_addr_i == $past(reg_addr_i, 2) |=> reg_rdata_o == $past(reg_wdata_i, 3); endproperty
  a_sel_rw: assert property (p_sel_rw) else $error("select readback");
  property p_inv_wr; ce_i && reg_we_i && reg_addr_i == 4'h4 && !soft_rst_i
    |=> cell_output_invert_o == $past(reg_wdata_i[7]); endproperty
  a_inv_wr: assert property (p_inv_wr) else $error("cell invert");
  property p_frz_gate; !ce_i |=> $stable(gate_o); endproperty
  a_frz_gate: assert property (p_frz_gate) else $error("gate moved");
  property p_frz_rd; !ce_i |=> $stable(reg_rdata_o) && $stable(cell_output_invert_o); endproperty
  a_frz_rd: assert property (p_frz_rd) else $error("frozen read");
  property p_soft; ce_i && soft_rst_i |=> reg_rdata_o == 8'h00 && !cell_output_invert_o; endproperty
  a_soft: assert property (p_soft) else $error("soft reset");
endmodule : lcgs_gate_select_assertions
bind lcgs_gate_select lcgs_gate_select_assertions lcgs_gate_select_assertions_i (.sys_clk_i, .rst_i, .soft_rst_i,
  .ce_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .src_i, .cell_status_i, .gate_o,
  .cell_output_invert_o);
`default_nettype wire

// ===== sim/tb_lcgs_gate_select.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; $display("mismatch %0t %h %h", $time, a, e); end end
module tb_lcgs_gate_select;
  logic sys_clk_i = 0, rst_i = 1, soft_rst_i = 0, ce_i = 1, reg_we_i = 0, reg_re_i = 0, cell_output_invert_o;
  logic [3:0] reg_addr_i = 0, cell_status_i = 0, gate_o;
  logic [7:0] reg_wdata_i = 0, reg_rdata_o, pol = 0;
  logic [31:0] src_i = 0, rnd = 32'h16dd;
  logic [7:0] sel [4];
  logic [4:0] ss [4];
  int num_errors = 0, cmp_count = 0, cyc = 0;
  lcgs_gate_select lcgs_gate_select_i (.sys_clk_i, .rst_i, .soft_rst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
    .reg_re_i, .reg_rdata_o, .src_i, .cell_status_i, .gate_o, .cell_output_invert_o);
  // Clock of 50 ns
  always #25 sys_clk_i = ~sys_clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Model: each gate ORs its chosen true and inverted inputs, then applies its own polarity
  function automatic logic [3:0] exp_gates();
    logic [7:0] v;
    logic [3:0] r;
    for (int k = 0; k < 4; k++) begin
      v[2*k+1] = src_i[ss[k]];
      v[2*k] = ~src_i[ss[k]];
    end
    for (int k = 0; k < 4; k++) begin
      r[k] = (|(sel[k] & v)) ^ pol[k];
    end
    return r;
  endfunction : exp_gates
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_we_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_re_i <= 1'b0;
    #1;
    `CHK(reg_rdata_o, e)
  endtask : rd
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // Hang guard; a normal run takes well under a thousand cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    // Empty selections after reset must give zero gates and a zero mirror
    @(posedge sys_clk_i);
    #1;
    `CHK(gate_o, 4'h0)
    rd(4'h9, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      ss[i] = rnd[4:0];
      wr(4'(i + 5), rnd[7:0]);
      rd(4'(i + 5), {3'h0, ss[i]});
    end
    for (int it = 0; it < 16; it++) begin
      for (int g = 0; g < 4; g++) begin
        rnd = lfsr(rnd);
        sel[g] = rnd[15:8];
        wr(4'(g), sel[g]);
        rd(4'(g), sel[g]);
      end
      rnd = lfsr(rnd);
      pol = rnd[7:0];
      wr(4'h4, pol);
      rd(4'h4, pol & 8'h8f);
      @(posedge sys_clk_i);
      rnd = lfsr(rnd);
      src_i <= rnd;
      cell_status_i <= rnd[11:8];
      // Source change needs five edges to reach the gates
      repeat (7) @(posedge sys_clk_i);
      #1;
      `CHK(gate_o, exp_gates())
      `CHK(cell_output_invert_o, pol[7])
      rd(4'h9, {4'h0, cell_status_i});
      wr(4'h9 + 4'(it % 7), 8'hff);
      rd(4'h9 + 4'(it % 7), (it % 7 == 0) ? {4'h0, cell_status_i} : 8'h00);
    end
    @(posedge sys_clk_i);
    soft_rst_i <= 1'b1;
    @(posedge sys_clk_i);
    soft_rst_i <= 1'b0;
    rd(4'h4, pol & 8'h0f);
    rd(4'h2, sel[2]);
    // A write while the clock enable is low must be dropped
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    reg_we_i <= 1'b1;
    reg_addr_i <= 4'h1;
    reg_wdata_i <= ~sel[1];
    @(posedge sys_clk_i);
    ce_i <= 1'b1;
    reg_we_i <= 1'b0;
    rd(4'h1, sel[1]);
    report_and_stop();
  end
endmodule : tb_lcgs_gate_select
`default_nettype wire
